// ===== sct_convert_train.sv
// Convert pulse train for one scanned multiplexed module.
`timescale 1ns/1ps
module sct_convert_train
	import sct_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	sct_train_if.train tif
);
	sct_train_state_t state_reg;
	logic [CH_W-1:0]  left_reg;
	logic [CH_W-1:0]  ch_reg;
	logic [CNT_W:0]   gap_reg;
	logic [CNT_W:0]   gap_cnt_reg;
	logic [CNT_W:0]   acc_reg;
	logic [CNT_W-1:0] per_reg;
	logic             pad_reg;
	logic             pulse_reg;
	logic             start;
	logic             fire;
	logic [CNT_W:0]   gap_full;

	assign gap_full = {1'b0, tif.conv_cyc} + {1'b0, SETTLE_CYC};
	assign start    = tif.strobe && tif.enable && (tif.chans != '0);
	// Padded mode counts a fixed gap; even mode spreads the pulses by accumulation.
	assign fire     = (state_reg == TR_RUN) &&
		(pad_reg ? (gap_cnt_reg == '0) : (acc_reg >= {1'b0, per_reg}));

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg <= TR_IDLE;
			left_reg  <= '0;
		end
		else if (start)
		begin
			state_reg <= TR_RUN;
			left_reg  <= tif.chans;
		end
		else if (fire)
		begin
			left_reg <= left_reg - 1'b1;
			if (left_reg == 5'h01)
				state_reg <= TR_IDLE;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pad_reg     <= 1'b0;
			gap_reg     <= '0;
			gap_cnt_reg <= '0;
			acc_reg     <= '0;
			per_reg     <= '0;
			ch_reg      <= '0;
		end
		else if (start)
		begin
			pad_reg     <= tif.pad_mode;
			gap_reg     <= gap_full;
			gap_cnt_reg <= '0;
			acc_reg     <= {1'b0, tif.period};
			per_reg     <= tif.period;
			ch_reg      <= tif.chans;
		end
		else if (state_reg == TR_RUN)
		begin
			gap_cnt_reg <= fire ? gap_reg - 1'b1 : gap_cnt_reg - 1'b1;
			acc_reg     <= (fire ? acc_reg - {1'b0, per_reg} : acc_reg) +
				(CNT_W+1)'(ch_reg);
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			pulse_reg <= 1'b0;
		else
			pulse_reg <= fire;
	end

	assign tif.pulse = pulse_reg;
	assign tif.busy  = (state_reg == TR_RUN);

	logic [CH_W-1:0]  pcount_reg;
	logic [CNT_W:0]   since_reg;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pcount_reg <= '0;
			since_reg  <= '0;
		end
		else
		begin
			pcount_reg <= start ? '0 : (fire ? pcount_reg + 1'b1 : pcount_reg);
			since_reg  <= fire ? (CNT_W+1)'(1) : since_reg + 1'b1;
		end
	end

	AST_TRAIN_START: assert property (@(posedge clk) disable iff (!rst_n)
		start |-> ##2 tif.pulse)
		else $error("Convert train did not start after the sample strobe.");
	AST_TRAIN_COUNT: assert property (@(posedge clk) disable iff (!rst_n)
		$fell(tif.busy) && !$past(start) |-> pcount_reg == ch_reg)
		else $error("Convert pulse count differs from the channel count.");
	AST_PAD_GAP: assert property (@(posedge clk) disable iff (!rst_n)
		fire && pad_reg && pcount_reg != '0 |-> since_reg == gap_reg)
		else $error("Padded convert spacing is wrong.");
	COV_PAD_TRAIN: cover property (@(posedge clk) disable iff (!rst_n)
		fire && pad_reg && left_reg == 5'h01);
	COV_EVEN_TRAIN: cover property (@(posedge clk) disable iff (!rst_n)
		fire && !pad_reg && left_reg == 5'h01);
endmodule : sct_convert_train

// ===== sct_mod_model.sv
// Behavioural model of the slow and oversampling converter modules in the slots.
`timescale 1ns/1ps
module sct_mod_model
	import sct_pkg::*;
#(
	parameter int NSLOW = 2,
	parameter int DW    = 24
)(
	input wire logic             clk,
	input wire logic             rst_n,
	input wire logic [NSLOW-1:0] start,
	output logic [NSLOW-1:0]     done,
	output logic [NSLOW*DW-1:0]  value,
	output logic [1:0]           tick,
	output logic                 strobe
);
	logic [7:0] cnt_reg;
	logic [7:0] wait_reg [NSLOW];
	logic [7:0] seq_reg  [NSLOW];

	assign tick[0] = (cnt_reg[1:0] == 2'h0);
	assign tick[1] = (cnt_reg[2:0] == 3'h0);
	assign strobe  = cnt_reg[5];

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_reg <= 8'h00;
			done    <= '0;
			value   <= '0;
			for (int s = 0; s < NSLOW; s++)
			begin
				wait_reg[s] <= 8'h00;
				seq_reg[s]  <= 8'h00;
			end
		end
		else
		begin
			cnt_reg <= cnt_reg + 8'h01;
			for (int s = 0; s < NSLOW; s++)
			begin
				// A slow converter takes far longer than one sample period.
				if (start[s])
					wait_reg[s] <= 8'hC8;
				else if (wait_reg[s] != 8'h00)
					wait_reg[s] <= wait_reg[s] - 8'h01;
				done[s] <= (wait_reg[s] == 8'h01);
				// Outside the done cycle the lines carry the inverse, never a stale word.
				if (wait_reg[s] == 8'h01)
					value[s*DW +: DW] <= DW'({8'hA0 + 8'(s), 8'h00, seq_reg[s]});
				else
					value[s*DW +: DW] <= ~DW'({8'hA0 + 8'(s), 8'h00, seq_reg[s]});
				if (wait_reg[s] == 8'h01)
					seq_reg[s] <= seq_reg[s] + 8'h01;
			end
		end
	end
endmodule : sct_mod_model

// ===== sct_pair_buf.sv
// Small valid/ready buffer between the sample word source and its reader.
`timescale 1ns/1ps
module sct_pair_buf #(
	parameter int W     = 8,
	parameter int DEPTH = 2
)(
	input wire logic         clk,
	input wire logic         rst_n,
	input wire logic         in_valid,
	output logic             in_ready,
	input wire logic [W-1:0] in_data,
	output logic             out_valid,
	input wire logic         out_ready,
	output logic [W-1:0]     out_data
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	generate
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
			$error("Buffer depth must be a power of two of at least two.");
	endgenerate

	logic [W-1:0] mem_reg [DEPTH];
	logic [PW-1:0] wr_reg;
	logic [PW-1:0] rd_reg;
	logic [PW:0]   count_reg;
	logic          push;
	logic          pop;

	assign in_ready  = (count_reg != (PW+1)'(DEPTH));
	assign out_valid = (count_reg != '0);
	assign out_data  = mem_reg[rd_reg];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_reg    <= '0;
			rd_reg    <= '0;
			count_reg <= '0;
		end
		else
		begin
			wr_reg    <= push ? wr_reg + 1'b1 : wr_reg;
			rd_reg    <= pop ? rd_reg + 1'b1 : rd_reg;
			count_reg <= count_reg + (PW+1)'(push) - (PW+1)'(pop);
		end
	end

	always_ff @(posedge clk)
	begin
		if (push)
			mem_reg[wr_reg] <= in_data;
	end

	// A stalled reader must see the same head word until it takes it.
	AST_BUF_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
		out_valid && !out_ready |=> out_valid && $stable(out_data))
		else $error("Buffer head changed while the reader stalled.");
endmodule : sct_pair_buf

// ===== sct_pkg.sv
// Shared constants and types for the scan convert timing block.
package sct_pkg;
	localparam int                CNT_W       = 16;
	localparam int                CH_W        = 5;
	localparam int                CLK_HZ      = 50_000_000;
	// Inter-channel settling gap, in nanoseconds.
	localparam int                SETTLE_NS   = 10_000;
	localparam int                SETTLE_CYC_I = (SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam logic [CNT_W-1:0]  SETTLE_CYC  = CNT_W'(SETTLE_CYC_I);
	localparam logic [2:0]        SYNC_CYC    = 3'h4;
	localparam logic [CNT_W-1:0]  PERIOD_INIT = 16'hFFFF;
	localparam logic [CNT_W-1:0]  ONE_CNT     = 16'h0001;
	typedef enum logic {TR_IDLE, TR_RUN} sct_train_state_t;
endpackage : sct_pkg

// ===== sct_scan_convert_timing.sv
// Sample strobe, convert pulse, sync and slow-module timing for analog input.
// Function
// - Sample strobe starts convert trains per scanned module
// - One convert pulse per enabled channel
// - Fastest rate plus 10 us settling gap
// - Too short a period spreads pulses evenly
// - Same settling gap for all scanned modules
// - Simultaneous modules capture once per strobe
// - One shared oversample clock is the timebase
// - Highest oversample frequency chosen by default
// - Sample rate is timebase divided by integer
// - Oversampling modules supply the sample strobe
// - One sync pulse to all oversampling modules
// - Sync and oversample clock routable to terminals
// - Slow module repeats last value until new
// - Slow first value at commit, second after start
// - Single-point mode flags a repeated slow value as not new
// - Each strobe starts one whole sample
// - Strobe divided down from selected timebase
`timescale 1ns/1ps
module sct_scan_convert_timing
	import sct_pkg::*;
#(
	parameter int NSCAN = 4,
	parameter int NOVS  = 2,
	parameter int NSLOW = 2,
	parameter int DW    = 24,
	parameter int IDX_W = 1
)(
	input wire logic                            CORE_CLK,
	input wire logic                            RESETN,
	input wire logic                            TASK_COMMIT,
	input wire logic                            TASK_RUN,
	input wire logic                            ACQ_START_EVENT,
	input wire logic                            SINGLE_POINT,
	input wire logic [sct_pkg::CNT_W-1:0]       SAMPLE_DIVISOR,
	input wire logic [NOVS-1:0]                 OVS_PRESENT,
	input wire logic [NOVS-1:0]                 OVS_TICK,
	input wire logic [NOVS*sct_pkg::CNT_W-1:0]  OVS_FREQ,
	input wire logic                            TB_FORCE_EN,
	input wire logic [IDX_W-1:0]                TB_FORCE_IDX,
	input wire logic                            OVS_STROBE_IN,
	input wire logic [NSCAN-1:0]                SCAN_EN,
	input wire logic [NSCAN*sct_pkg::CH_W-1:0]  SCAN_CHANS,
	input wire logic [NSCAN*sct_pkg::CNT_W-1:0] SCAN_CONV_CYC,
	output logic [NSCAN-1:0]                    CONVERT_PULSE,
	output logic                                SIMUL_HOLD_STROBE,
	output logic                                SAMPLE_STROBE,
	input wire logic                            SYNC_ROUTE_EN,
	input wire logic                            SYNC_DIR_OUT,
	input wire logic                            SYNC_PFT_I,
	output logic                                SYNC_PFT_O,
	output logic                                SYNC_PFT_OE,
	output logic                                OVS_SYNC,
	input wire logic                            OVSCLK_ROUTE_EN,
	input wire logic                            OVSCLK_DIR_OUT,
	input wire logic                            OVSCLK_PFT_I,
	output logic                                OVSCLK_PFT_O,
	output logic                                OVSCLK_PFT_OE,
	input wire logic [NSLOW-1:0]                SLOW_DONE,
	input wire logic [NSLOW*DW-1:0]             SLOW_VALUE,
	output logic [NSLOW-1:0]                    SLOW_START,
	output logic                                OUT_VALID,
	input wire logic                            OUT_READY,
	output logic [NSLOW*(DW+1)-1:0]             OUT_DATA,
	output logic                                OVERRUN
);
	import sct_pkg::*;

	localparam int WW = NSLOW * (DW + 1);

	generate
		if (NOVS > (1 << IDX_W) || NSCAN < 1 || NSLOW < 1 || DW < 1)
			$error("Module counts do not fit the configured widths.");
	endgenerate

	logic                 ovs_any;
	logic [IDX_W-1:0]     best_idx;
	logic [CNT_W-1:0]     best_f;
	logic [IDX_W-1:0]     sel_idx;
	logic                 clk_in_pft;
	logic                 sync_in_pft;
	logic                 pft_clk_q_reg;
	logic                 tb_tick;
	logic                 ovs_tog_reg;

	assign ovs_any     = |OVS_PRESENT;
	assign clk_in_pft  = OVSCLK_ROUTE_EN && !OVSCLK_DIR_OUT;
	assign sync_in_pft = SYNC_ROUTE_EN && !SYNC_DIR_OUT;

	always_comb
	begin
		best_idx = '0;
		best_f   = '0;
		for (int i = 0; i < NOVS; i++)
		begin
			if (OVS_PRESENT[i] && OVS_FREQ[i*CNT_W +: CNT_W] > best_f)
			begin
				best_idx = IDX_W'(i);
				best_f   = OVS_FREQ[i*CNT_W +: CNT_W];
			end
		end
	end

	assign sel_idx = TB_FORCE_EN ? TB_FORCE_IDX : best_idx;
	// Every edge of the routed-in clock is one timebase tick; the outbound copy toggles per tick.
	assign tb_tick = clk_in_pft ? (OVSCLK_PFT_I ^ pft_clk_q_reg) :
		(ovs_any ? OVS_TICK[sel_idx] : 1'b1);

	always_ff @(posedge CORE_CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			pft_clk_q_reg <= 1'b0;
			ovs_tog_reg   <= 1'b0;
		end
		else
		begin
			pft_clk_q_reg <= OVSCLK_PFT_I;
			ovs_tog_reg   <= tb_tick ? !ovs_tog_reg : ovs_tog_reg;
		end
	end

	assign OVSCLK_PFT_O  = ovs_tog_reg;
	assign OVSCLK_PFT_OE = OVSCLK_ROUTE_EN && OVSCLK_DIR_OUT;

	logic [CNT_W-1:0] div_cnt_reg;
	logic [CNT_W-1:0] div_last;
	logic             int_strobe;
	logic             ovs_strobe_q_reg;
	logic             ext_rise;
	logic             strobe_now;
	logic             push_ready;

	assign div_last   = (SAMPLE_DIVISOR == '0) ? '0 : SAMPLE_DIVISOR - ONE_CNT;
	// The internal divider waits while the sample buffer is full so no word is lost.
	assign int_strobe = TASK_RUN && tb_tick && push_ready && (div_cnt_reg == div_last);
	assign ext_rise   = OVS_STROBE_IN && !ovs_strobe_q_reg;
	assign strobe_now = TASK_RUN && (ovs_any ? ext_rise : int_strobe);

	always_ff @(posedge CORE_CLK or negedge RESETN)
	begin
		if (!RESETN)
			div_cnt_reg <= '0;
		else if (!TASK_RUN || TASK_COMMIT)
			div_cnt_reg <= '0;
		else if (tb_tick && push_ready)
			div_cnt_reg <= (div_cnt_reg >= div_last) ? '0 : div_cnt_reg + ONE_CNT;
	end

	always_ff @(posedge CORE_CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			ovs_strobe_q_reg  <= 1'b0;
			SAMPLE_STROBE     <= 1'b0;
			SIMUL_HOLD_STROBE <= 1'b0;
		end
		else
		begin
			ovs_strobe_q_reg  <= OVS_STROBE_IN;
			SAMPLE_STROBE     <= strobe_now;
			SIMUL_HOLD_STROBE <= strobe_now;
		end
	end

	logic [CNT_W-1:0] per_cnt_reg;
	logic [CNT_W-1:0] period_reg;
	logic             pad_ok;
	logic [CH_W+CNT_W:0] need;

	always_ff @(posedge CORE_CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			per_cnt_reg <= '0;
			period_reg  <= PERIOD_INIT;
		end
		else if (strobe_now)
		begin
			per_cnt_reg <= ONE_CNT;
			period_reg  <= (per_cnt_reg == '0) ? PERIOD_INIT : per_cnt_reg;
		end
		else if (per_cnt_reg != PERIOD_INIT && per_cnt_reg != '0)
			per_cnt_reg <= per_cnt_reg + ONE_CNT;
	end

	// Padding is all or nothing across the task, so the spacing choice is shared.
	always_comb
	begin
		pad_ok = 1'b1;
		need   = '0;
		for (int m = 0; m < NSCAN; m++)
		begin
			need = (CH_W+CNT_W+1)'(SCAN_CHANS[m*CH_W +: CH_W]) *
				((CH_W+CNT_W+1)'(SCAN_CONV_CYC[m*CNT_W +: CNT_W]) +
				(CH_W+CNT_W+1)'(SETTLE_CYC));
			if (SCAN_EN[m] && need > (CH_W+CNT_W+1)'(period_reg))
				pad_ok = 1'b0;
		end
	end

	genvar g;
	generate
		for (g = 0; g < NSCAN; g++)
		begin : g_train
			sct_train_if tif ();
			assign tif.strobe   = strobe_now;
			assign tif.enable   = SCAN_EN[g];
			assign tif.pad_mode = pad_ok;
			assign tif.chans    = SCAN_CHANS[g*CH_W +: CH_W];
			assign tif.conv_cyc = SCAN_CONV_CYC[g*CNT_W +: CNT_W];
			assign tif.period   = period_reg;
			assign CONVERT_PULSE[g] = tif.pulse;
			sct_convert_train u_train (
				.clk   (CORE_CLK),
				.rst_n (RESETN),
				.tif   (tif.train)
			);
		end
	endgenerate

	logic [2:0] sync_cnt_reg;
	logic       sync_gen_reg;

	always_ff @(posedge CORE_CLK or negedge RESETN)
	begin
		if (!RESETN)
			sync_cnt_reg <= '0;
		else if (TASK_COMMIT && ovs_any && !sync_in_pft)
			sync_cnt_reg <= SYNC_CYC;
		else if (sync_cnt_reg != '0)
			sync_cnt_reg <= sync_cnt_reg - 1'b1;
	end

	always_ff @(posedge CORE_CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			sync_gen_reg <= 1'b0;
			OVS_SYNC     <= 1'b0;
		end
		else
		begin
			sync_gen_reg <= (sync_cnt_reg != '0);
			OVS_SYNC     <= sync_in_pft ? SYNC_PFT_I : (sync_cnt_reg != '0);
		end
	end

	assign SYNC_PFT_O  = sync_gen_reg;
	assign SYNC_PFT_OE = SYNC_ROUTE_EN && SYNC_DIR_OUT;

	logic [DW-1:0]    hold_reg [NSLOW];
	logic [NSLOW-1:0] fresh_reg;
	logic             started_reg;
	logic [WW-1:0]    word;
	logic             push_fire;

	assign push_fire = strobe_now && push_ready;

	always_ff @(posedge CORE_CLK or negedge RESETN)
	begin
		if (!RESETN)
			started_reg <= 1'b0;
		else if (ACQ_START_EVENT)
			started_reg <= 1'b1;
		else if (TASK_COMMIT)
			started_reg <= 1'b0;
	end

	always_ff @(posedge CORE_CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			SLOW_START <= '0;
			fresh_reg  <= '0;
			for (int s = 0; s < NSLOW; s++)
				hold_reg[s] <= '0;
		end
		else
		begin
			for (int s = 0; s < NSLOW; s++)
			begin
				SLOW_START[s] <= TASK_COMMIT || ACQ_START_EVENT ||
					(SLOW_DONE[s] && started_reg && TASK_RUN);
				if (SLOW_DONE[s])
					hold_reg[s] <= SLOW_VALUE[s*DW +: DW];
				// A completion in the same cycle as a push keeps the value fresh.
				fresh_reg[s] <= SLOW_DONE[s] || (fresh_reg[s] && !push_fire);
			end
		end
	end

	always_comb
	begin
		word = '0;
		for (int s = 0; s < NSLOW; s++)
			word[s*(DW+1) +: DW+1] = {(SINGLE_POINT ? fresh_reg[s] : 1'b1), hold_reg[s]};
	end

	always_ff @(posedge CORE_CLK or negedge RESETN)
	begin
		if (!RESETN)
			OVERRUN <= 1'b0;
		else if (strobe_now && !push_ready)
			OVERRUN <= 1'b1;
		else if (TASK_COMMIT)
			OVERRUN <= 1'b0;
	end

	sct_pair_buf #(
		.W     (WW),
		.DEPTH (2)
	) u_buf (
		.clk       (CORE_CLK),
		.rst_n     (RESETN),
		.in_valid  (strobe_now),
		.in_ready  (push_ready),
		.in_data   (word),
		.out_valid (OUT_VALID),
		.out_ready (OUT_READY),
		.out_data  (OUT_DATA)
	);

	AST_SIMUL: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		strobe_now |=> SIMUL_HOLD_STROBE && SAMPLE_STROBE)
		else $error("Simultaneous modules missed the sample strobe.");
	AST_OVS_SRC: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		TASK_RUN && ovs_any && ext_rise |=> SAMPLE_STROBE)
		else $error("Oversampling strobe did not become the sample strobe.");
	AST_SYNC: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		TASK_COMMIT && ovs_any && !sync_in_pft |-> ##2 OVS_SYNC [*4])
		else $error("Synchronization pulse has the wrong length.");
	AST_SLOW_FIRST: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		TASK_COMMIT || ACQ_START_EVENT |=> &SLOW_START)
		else $error("Slow module conversion not requested.");
	AST_HOLD: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		!SLOW_DONE[0] |=> $stable(hold_reg[0]))
		else $error("Slow hold register changed without a completion.");
	AST_SINGLE: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		push_fire && !SLOW_DONE[0] |=> !fresh_reg[0])
		else $error("Slow value stayed fresh after being reported.");
	COV_OVS_STROBE: cover property (@(posedge CORE_CLK) disable iff (!RESETN)
		ovs_any && strobe_now);
	COV_SYNC: cover property (@(posedge CORE_CLK) disable iff (!RESETN) $rose(OVS_SYNC));
	COV_OVERRUN: cover property (@(posedge CORE_CLK) disable iff (!RESETN) $rose(OVERRUN));
endmodule : sct_scan_convert_timing

// ===== sct_scan_convert_timing_tb.sv
// Self-checking bench for the scan convert timing block.
`timescale 1ns/1ps
module sct_scan_convert_timing_tb;
	import sct_pkg::*;
	logic        clk = 1'b0, rst_n = 1'b0, commit = 1'b0, run = 1'b0, start_ev = 1'b0;
	logic        single = 1'b0, fe = 1'b0, fidx = 1'b0, sy_en = 1'b0, sy_dir = 1'b0;
	logic        sy_i = 1'b0, ck_en = 1'b0, ck_dir = 1'b0, ck_i = 1'b0, rdy = 1'b0;
	logic [15:0] div = 16'h04B0;
	logic [1:0]  ovs_p = 2'h0;
	logic [31:0] freq = {16'h0001, 16'h0002};
	logic [3:0]  scan_en = 4'h3;
	logic [19:0] chans = {5'h00, 5'h00, 5'h02, 5'h02};
	logic [63:0] conv = {16'h0000, 16'h0000, 16'h0014, 16'h000A};
	logic [3:0]  cp;
	logic [1:0]  tick, s_start, s_done;
	logic [47:0] s_val;
	logic [49:0] odata;
	logic        hold_stb, smp_stb, sy_o, sy_oe, ovs_sync, ck_o, ck_oe, ovs_stb;
	logic        ovalid, overrun, ck_last;
	int          n_errors = 0, tests_run = 0, cyc = 0, n_stb, n_hold, n_sync, n_syo;
	int          n_ss, n_ck, n_c0, n_c1, gap0, gap1, f0, f1, sgap, lstb, l0, l1, n_dn;

	sct_scan_convert_timing uut (.CORE_CLK(clk), .RESETN(rst_n), .TASK_COMMIT(commit),
		.TASK_RUN(run), .ACQ_START_EVENT(start_ev), .SINGLE_POINT(single),
		.SAMPLE_DIVISOR(div), .OVS_PRESENT(ovs_p), .OVS_TICK(tick), .OVS_FREQ(freq),
		.TB_FORCE_EN(fe), .TB_FORCE_IDX(fidx), .OVS_STROBE_IN(ovs_stb), .SCAN_EN(scan_en),
		.SCAN_CHANS(chans), .SCAN_CONV_CYC(conv), .CONVERT_PULSE(cp),
		.SIMUL_HOLD_STROBE(hold_stb), .SAMPLE_STROBE(smp_stb), .SYNC_ROUTE_EN(sy_en),
		.SYNC_DIR_OUT(sy_dir), .SYNC_PFT_I(sy_i), .SYNC_PFT_O(sy_o), .SYNC_PFT_OE(sy_oe),
		.OVS_SYNC(ovs_sync), .OVSCLK_ROUTE_EN(ck_en), .OVSCLK_DIR_OUT(ck_dir),
		.OVSCLK_PFT_I(ck_i), .OVSCLK_PFT_O(ck_o), .OVSCLK_PFT_OE(ck_oe),
		.SLOW_DONE(s_done), .SLOW_VALUE(s_val), .SLOW_START(s_start), .OUT_VALID(ovalid),
		.OUT_READY(rdy), .OUT_DATA(odata), .OVERRUN(overrun));

	sct_mod_model #(.NSLOW(2), .DW(24)) mods (.clk(clk), .rst_n(rst_n), .start(s_start),
		.done(s_done), .value(s_val), .tick(tick), .strobe(ovs_stb));

	initial
	begin
		forever #10 clk = ~clk;
	end

	// Counts and spacings are gathered here so the scenarios can judge whole windows.
	always @(posedge clk)
	begin
		cyc++;
		n_stb  += (smp_stb === 1'b1);
		n_hold += (hold_stb === 1'b1);
		n_sync += (ovs_sync === 1'b1);
		n_syo  += (sy_o === 1'b1);
		n_ss   += (s_start[0] === 1'b1);
		n_dn   += (s_done[0] === 1'b1);
		n_ck   += (ck_o !== ck_last);
		ck_last = ck_o;
		if (smp_stb === 1'b1)
		begin
			sgap = cyc - lstb;
			lstb = cyc;
		end
		if (cp[0] === 1'b1)
		begin
			n_c0++;
			gap0 = cyc - l0;
			l0   = cyc;
			f0   = (n_c0 == 1) ? cyc : f0;
		end
		if (cp[1] === 1'b1)
		begin
			n_c1++;
			gap1 = cyc - l1;
			l1   = cyc;
			f1   = (n_c1 == 1) ? cyc : f1;
		end
	end

	task stop_test;
		if (n_errors == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : stop_test

	task check(input logic [63:0] seen, input logic [63:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check

	task fail_if(input bit b);
		if (b)
		begin
			n_errors++;
			stop_test();
		end
	endtask : fail_if

	task clr;
		{n_stb, n_hold, n_sync, n_syo, n_ss, n_ck, n_c0, n_c1, n_dn} = '0;
	endtask : clr

	task wait_stb(input int lim);
		int n0;
		int i;
		n0 = n_stb;
		for (i = 0; i < lim && n_stb == n0; i++)
			@(negedge clk);
		fail_if(n_stb == n0);
	endtask : wait_stb

	task pop(input logic [24:0] exp);
		int i;
		for (i = 0; i < 100 && ovalid !== 1'b1; i++)
			@(negedge clk);
		fail_if(i == 100);
		check(odata[24:0], exp);
		// Ready stays high between pops; each head is judged before the edge that takes it.
		rdy = 1'b1;
		@(negedge clk);
	endtask : pop

	task t_sync;
		ovs_p  = 2'h1;
		sy_en  = 1'b1;
		sy_dir = 1'b1;
		clr();
		commit = 1'b1;
		@(negedge clk);
		commit = 1'b0;
		repeat (12) @(negedge clk);
		check(sy_oe, 64'h1);
		check(n_sync, 64'h4);
		check(n_syo, 64'h4);
		check(n_ss, 64'h1);
		sy_dir = 1'b0;
		clr();
		sy_i = 1'b1;
		repeat (3) @(negedge clk);
		sy_i = 1'b0;
		repeat (4) @(negedge clk);
		check(sy_oe, 64'h0);
		check(n_sync, 64'h3);
		sy_en = 1'b0;
	endtask : t_sync

	task t_clk;
		ovs_p  = 2'h3;
		ck_en  = 1'b1;
		ck_dir = 1'b1;
		clr();
		repeat (80) @(negedge clk);
		check(ck_oe, 64'h1);
		check(n_ck >= 19 && n_ck <= 21, 64'h1);
		fe   = 1'b1;
		fidx = 1'b1;
		repeat (8) @(negedge clk);
		clr();
		repeat (80) @(negedge clk);
		check(n_ck >= 9 && n_ck <= 11, 64'h1);
		fe = 1'b0;
		ck_dir = 1'b0;
		clr();
		repeat (20)
		begin
			ck_i = ~ck_i;
			repeat (2) @(negedge clk);
		end
		check(ck_oe, 64'h0);
		check(n_ck >= 19 && n_ck <= 21, 64'h1);
		ck_en = 1'b0;
	endtask : t_clk

	task t_pad;
		ovs_p = 2'h0;
		run   = 1'b1;
		rdy   = 1'b1;
		wait_stb(1300);
		wait_stb(1300);
		clr();
		wait_stb(1300);
		check(sgap, 64'd1200);
		check(n_c0, 64'h2);
		check(n_c1, 64'h2);
		check(gap0, 64'd10 + SETTLE_CYC);
		check(gap1, 64'd20 + SETTLE_CYC);
		check(f0 == f1, 64'h1);
		check(n_hold, 64'h1);
	endtask : t_pad

	task t_even;
		div = 16'h012C;
		wait_stb(400);
		wait_stb(400);
		clr();
		wait_stb(400);
		check(sgap, 64'd300);
		check(n_c0, 64'h2);
		check(gap0 >= 140 && gap0 <= 160, 64'h1);
	endtask : t_even

	task t_buf;
		int i;
		single   = 1'b1;
		div      = 16'h0032;
		rdy      = 1'b0;
		clr();
		start_ev = 1'b1;
		@(negedge clk);
		start_ev = 1'b0;
		for (i = 0; i < 300 && n_dn == 0; i++)
			@(negedge clk);
		fail_if(n_dn == 0);
		repeat (5) @(negedge clk);
		check(n_stb, 64'h2);
		pop({1'b0, 24'hA00000});
		pop({1'b0, 24'hA00000});
		pop({1'b1, 24'hA00001});
		pop({1'b0, 24'hA00001});
		single = 1'b0;
	endtask : t_buf

	task t_ovs;
		ovs_p = 2'h3;
		rdy   = 1'b1;
		wait_stb(200);
		wait_stb(200);
		clr();
		wait_stb(200);
		check(sgap, 64'd64);
		check(n_c0, 64'h2);
		rdy = 1'b0;
		repeat (300) @(negedge clk);
		check(overrun, 64'h1);
		check(odata[24], 64'h1);
	endtask : t_ovs

	initial
	begin
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		t_sync();
		t_clk();
		t_pad();
		t_even();
		t_buf();
		t_ovs();
		stop_test();
	end
endmodule : sct_scan_convert_timing_tb

// ===== sct_train_if.sv
// Carrier between the timing core and one convert pulse train.
`timescale 1ns/1ps
interface sct_train_if;
	import sct_pkg::*;
	logic             strobe;
	logic             enable;
	logic             pad_mode;
	logic [CH_W-1:0]  chans;
	logic [CNT_W-1:0] conv_cyc;
	logic [CNT_W-1:0] period;
	logic             pulse;
	logic             busy;
	modport ctrl  (output strobe, enable, pad_mode, chans, conv_cyc, period, input pulse, busy);
	modport train (input strobe, enable, pad_mode, chans, conv_cyc, period, output pulse, busy);
endinterface : sct_train_if
